// file: rtl/hpc_regs.vh
// register map, field positions and reset values for the host port control block
`ifndef HPC_REGS_VH
`define HPC_REGS_VH
`define HPC_ADDR_CTRL1     5'h00
`define HPC_ADDR_CTRL2     5'h01
`define HPC_ADDR_SCRATCH   5'h02
`define HPC_ADDR_STATUS    5'h03
`define HPC_ADDR_CFGDATA   5'h04
`define HPC_CTRL2_CFG_IRQ  0
`define HPC_CTRL2_ERR_IRQ  1
`define HPC_CTRL2_USR_IRQ  2
`define HPC_CTRL2_CHAIN    3
`define HPC_CTRL2_HOLD     4
`define HPC_CTRL2_USER     5
`define HPC_CTRL2_MASK     8'h3F
`define HPC_CTRL2_RESET    8'h00
`define HPC_SCRATCH_RESET  8'h00
`define HPC_STAT_READY     1
`define HPC_STAT_PENDING   2
`define HPC_STAT_ERR_LO    3
`define HPC_STAT_INIT      6
`define HPC_STAT_DONE      7
`define HPC_SER_BITS       4'h8
`endif

// file: rtl/hpc_serializer.v
// serializer that shifts configuration bytes out on the daisy chain
`timescale 1ns/1ps
`default_nettype none
`include "hpc_regs.vh"
module hpc_serializer
(
   // clock and reset
   input  wire       clock,
   input  wire       reset_n,
   // byte in
   input  wire       load,
   input  wire [7:0] byte_in,
   // serial out
   output reg        busy_reg,
   output reg        chain_data_reg
);
   reg [7:0] shift_reg;
   reg [3:0] count_reg;

   always @(posedge clock)
   begin
      if (!reset_n)
      begin
         shift_reg      <= 8'h00;
         count_reg      <= 4'h0;
         busy_reg       <= 1'b0;
         chain_data_reg <= 1'b0;
      end
      else if (load && !busy_reg)
      begin
         shift_reg <= byte_in;
         count_reg <= `HPC_SER_BITS;
         busy_reg  <= 1'b1;
      end
      else if (busy_reg)
      begin
         // msb first
         chain_data_reg <= shift_reg[7];
         shift_reg      <= {shift_reg[6:0], 1'b0};
         count_reg      <= count_reg - 4'h1;
         if (count_reg == 4'h1)
            busy_reg <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: rtl/hpc_host_port.v
// host port control register two, scratchpad, status and interrupt logic
`timescale 1ns/1ps
`default_nettype none
`include "hpc_regs.vh"
module hpc_host_port
(
   // clock and reset
   input  wire       clock,
   input  wire       reset_n,
   // host register port
   input  wire [4:0] addr,
   input  wire       rd_strobe,
   input  wire       wr_strobe,
   input  wire [7:0] wr_data,
   output reg  [7:0] rd_data_reg,
   output reg        ack_reg,
   // configuration engine
   input  wire       config_mode,
   input  wire       data_request,
   input  wire [1:0] stream_error,
   input  wire       stream_user_enable,
   input  wire       done_pin,
   input  wire       init_pin,
   // user logic
   input  wire       user_request_n,
   // outputs
   output reg        irq_n_reg,
   output reg        user_mode_reg,
   output reg        chain_data_reg,
   output reg        chain_active_reg
);
   // ------------------------------------------------------------
   // acknowledge states
   // ------------------------------------------------------------
   localparam [1:0] ACK_IDLE = 2'b01;
   localparam [1:0] ACK_HOLD = 2'b10;

   // ------------------------------------------------------------
   // helper functions
   // ------------------------------------------------------------
   // strobe qualified by one register address
   function addr_hit;
      input       strobe;
      input [4:0] a;
      input [4:0] target;
      begin
         addr_hit = strobe && (a == target);
      end
   endfunction

   // interrupt source gated by its enable and its mode condition
   function source_on;
      input enable;
      input gate;
      input level;
      begin
         source_on = enable && gate && level;
      end
   endfunction

   // status byte assembled from its live fields; writes never reach it
   function [7:0] status_byte;
      input       ready;
      input       pending;
      input [1:0] error;
      input       init_level;
      input       done_level;
      begin
         status_byte                     = 8'h00;
         status_byte[`HPC_STAT_READY]    = ready;
         status_byte[`HPC_STAT_PENDING]  = pending;
         status_byte[`HPC_STAT_ERR_LO]   = error[0];
         status_byte[`HPC_STAT_ERR_LO+1] = error[1];
         status_byte[`HPC_STAT_INIT]     = init_level;
         status_byte[`HPC_STAT_DONE]     = done_level;
      end
   endfunction

   // read data for one register address; unmapped addresses read zero
   function [7:0] read_word;
      input [4:0] a;
      input [7:0] ctrl2;
      input [7:0] scratch;
      input [7:0] status;
      begin
         case (a)
            `HPC_ADDR_CTRL2:   read_word = ctrl2;
            `HPC_ADDR_SCRATCH: read_word = scratch;
            `HPC_ADDR_STATUS:  read_word = status;
            default:           read_word = 8'h00;
         endcase
      end
   endfunction

   // ------------------------------------------------------------
   // synchronisers for pins
   // ------------------------------------------------------------
   reg [1:0] usr_meta_reg;
   reg [1:0] done_meta_reg;
   reg [1:0] init_meta_reg;
   always @(posedge clock)
   begin
      if (!reset_n)
      begin
         usr_meta_reg  <= 2'b11;
         done_meta_reg <= 2'b00;
         init_meta_reg <= 2'b00;
      end
      else
      begin
         usr_meta_reg  <= {usr_meta_reg[0], user_request_n};
         done_meta_reg <= {done_meta_reg[0], done_pin};
         init_meta_reg <= {init_meta_reg[0], init_pin};
      end
   end
   wire usr_req   = ~usr_meta_reg[1];
   wire done_sync = done_meta_reg[1];
   wire init_sync = init_meta_reg[1];

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg  [7:0] ctrl2_reg;
   reg  [7:0] scratch_reg;
   reg        pending_reg;
   reg        done_seen_reg;
   reg  [1:0] ack_state_reg;
   reg  [1:0] ack_state_next;
   reg        ack_next;
   reg        ser_busy_d_reg;
   wire       ser_busy;
   wire       ser_data;
   wire       ser_load;

   wire wr_ctrl2   = addr_hit(wr_strobe, addr, `HPC_ADDR_CTRL2);
   wire wr_scratch = addr_hit(wr_strobe, addr, `HPC_ADDR_SCRATCH);
   wire rd_status  = addr_hit(rd_strobe, addr, `HPC_ADDR_STATUS);
   wire wr_cfg     = addr_hit(wr_strobe, addr, `HPC_ADDR_CFGDATA);

   wire cfg_irq_en = ctrl2_reg[`HPC_CTRL2_CFG_IRQ];
   wire err_irq_en = ctrl2_reg[`HPC_CTRL2_ERR_IRQ];
   wire usr_irq_en = ctrl2_reg[`HPC_CTRL2_USR_IRQ];
   wire chain_en   = ctrl2_reg[`HPC_CTRL2_CHAIN];
   wire hold_en    = ctrl2_reg[`HPC_CTRL2_HOLD];

   // ------------------------------------------------------------
   // interrupt sources
   // ------------------------------------------------------------
   wire src_cfg = source_on(cfg_irq_en, config_mode && chain_en, data_request);
   wire src_err = source_on(err_irq_en, config_mode, stream_error != 2'b00);
   wire src_usr = source_on(usr_irq_en, 1'b1, usr_req);
   wire any_src = src_cfg || src_err || src_usr;

   assign ser_load = wr_cfg && chain_en && config_mode;

   hpc_serializer u_ser
   (
      .clock          (clock),
      .reset_n        (reset_n),
      .load           (ser_load),
      .byte_in        (wr_data),
      .busy_reg       (ser_busy),
      .chain_data_reg (ser_data)
   );

   // ------------------------------------------------------------
   // control two and scratchpad
   // ------------------------------------------------------------
   always @(posedge clock)
   begin
      if (!reset_n)
      begin
         ctrl2_reg   <= `HPC_CTRL2_RESET;
         scratch_reg <= `HPC_SCRATCH_RESET;
      end
      else
      begin
         if (wr_ctrl2)
            ctrl2_reg <= wr_data & `HPC_CTRL2_MASK;
         if (wr_scratch)
            scratch_reg <= wr_data;
      end
   end

   // ------------------------------------------------------------
   // pending flag and interrupt output
   // ------------------------------------------------------------
   always @(posedge clock)
   begin
      if (!reset_n)
      begin
         pending_reg <= 1'b0;
         irq_n_reg   <= 1'b1;
      end
      else
      begin
         // set wins over the read clear
         if (any_src)
            pending_reg <= 1'b1;
         else if (rd_status)
            pending_reg <= 1'b0;
         irq_n_reg <= ~any_src;
      end
   end

   // ------------------------------------------------------------
   // user mode, latched at the rising edge of done
   // ------------------------------------------------------------
   always @(posedge clock)
   begin
      if (!reset_n)
      begin
         done_seen_reg <= 1'b0;
         user_mode_reg <= 1'b0;
      end
      else
      begin
         done_seen_reg <= done_sync;
         if (done_sync && !done_seen_reg)
            user_mode_reg <= ctrl2_reg[`HPC_CTRL2_USER] || stream_user_enable;
         else if (!done_sync)
            user_mode_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // chain outputs, active delayed to line up with the data bits
   // ------------------------------------------------------------
   always @(posedge clock)
   begin
      if (!reset_n)
      begin
         ser_busy_d_reg   <= 1'b0;
         chain_data_reg   <= 1'b0;
         chain_active_reg <= 1'b0;
      end
      else
      begin
         ser_busy_d_reg   <= ser_busy;
         chain_data_reg   <= ser_data;
         chain_active_reg <= ser_busy_d_reg;
      end
   end

   // ------------------------------------------------------------
   // acknowledge state machine
   // ------------------------------------------------------------
   // a held configuration write parks here until the serializer drains
   always @*
   begin
      ack_state_next = ack_state_reg;
      ack_next       = 1'b0;
      case (ack_state_reg)
         ACK_IDLE:
         begin
            if (ser_load && hold_en)
            begin
               ack_state_next = ACK_HOLD;
               ack_next       = 1'b0;
            end
            else
               ack_next = wr_strobe || rd_strobe;
         end
         ACK_HOLD:
         begin
            if (!ser_busy)
            begin
               ack_state_next = ACK_IDLE;
               ack_next       = 1'b1;
            end
         end
         default:
         begin
            ack_state_next = ACK_IDLE;
            ack_next       = 1'b0;
         end
      endcase
   end

   always @(posedge clock)
   begin
      if (!reset_n)
      begin
         ack_state_reg <= ACK_IDLE;
         ack_reg       <= 1'b0;
      end
      else
      begin
         ack_state_reg <= ack_state_next;
         ack_reg       <= ack_next;
      end
   end

   // ------------------------------------------------------------
   // read mux; status writes have no effect
   // ------------------------------------------------------------
   reg [7:0] status_val;
   always @*
   begin
      status_val = status_byte(data_request, pending_reg, stream_error,
                               init_sync, done_sync);
   end

   always @(posedge clock)
   begin
      if (!reset_n)
         rd_data_reg <= 8'h00;
      else if (rd_strobe)
         rd_data_reg <= read_word(addr, ctrl2_reg, scratch_reg, status_val);
   end
endmodule
`default_nettype wire

// file: tb/hpc_checker.sv
// assertions on the host port control block ports
`timescale 1ns/1ps
`default_nettype none
module hpc_checker
(
   // clock and reset
   input wire logic       clock,
   input wire logic       reset_n,
   // host port and sources
   input wire logic [4:0] addr,
   input wire logic       rd_strobe,
   input wire logic       wr_strobe,
   input wire logic [7:0] wr_data,
   input wire logic       config_mode,
   input wire logic       done_pin,
   input wire logic       user_request_n,
   // outputs
   input wire logic [7:0] rd_data_reg,
   input wire logic       ack_reg,
   input wire logic       irq_n_reg,
   input wire logic       user_mode_reg,
   input wire logic       chain_active_reg
);
   // ----
   // shadow of the writable registers
   // ----
   logic [7:0] c2_reg;
   logic [7:0] sp_reg;
   wire        cfg_wr = wr_strobe && addr == 5'h04;
   always @(posedge clock)
      if (!reset_n)
      begin
         c2_reg <= 8'h00;
         sp_reg <= 8'h00;
      end
      else if (wr_strobe && addr == 5'h01)
         c2_reg <= wr_data & 8'h3F;
      else if (wr_strobe && addr == 5'h02)
         sp_reg <= wr_data;
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   property p_rd_c2; rd_strobe && addr == 5'h01 |=> rd_data_reg == c2_reg; endproperty
   a_rd_c2: assert property (p_rd_c2) else $error("ctrl2 readback");
   property p_rd_sp; rd_strobe && addr == 5'h02 |=> rd_data_reg == sp_reg; endproperty
   a_rd_sp: assert property (p_rd_sp) else $error("scratch readback");
   property p_ack; rd_strobe || (wr_strobe && addr != 5'h04) |=> ack_reg; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_fast; cfg_wr && !c2_reg[4] |=> ack_reg; endproperty
   a_fast: assert property (p_fast) else $error("late ack");
   property p_hold;
      cfg_wr && c2_reg[4:3] == 2'h3 && config_mode && !chain_active_reg
         |=> !ack_reg [*2] ##[1:16] ack_reg;
   endproperty
   a_hold: assert property (p_hold) else $error("held ack");
   property p_nochain; cfg_wr && !c2_reg[3] && !chain_active_reg |=> !chain_active_reg [*3];
   endproperty
   a_nochain: assert property (p_nochain) else $error("shift while off");
   property p_chain; cfg_wr && c2_reg[3] && config_mode |-> ##[1:3] chain_active_reg; endproperty
   a_chain: assert property (p_chain) else $error("no shift");
   property p_usr; (c2_reg[2] && !user_request_n) [*5] |-> !irq_n_reg; endproperty
   a_usr: assert property (p_usr) else $error("user irq");
   property p_quiet; (c2_reg[2:0] == 3'h0) [*3] |-> irq_n_reg; endproperty
   a_quiet: assert property (p_quiet) else $error("irq while off");
   property p_umode; $rose(done_pin) && c2_reg[5] |-> ##[1:6] user_mode_reg; endproperty
   a_umode: assert property (p_umode) else $error("user mode");
   c_hold: cover property (cfg_wr && c2_reg[4]);
   c_irq: cover property (!irq_n_reg);
   c_umode: cover property (user_mode_reg);
endmodule
`default_nettype wire

// file: tb/hpc_host_model.sv
// host processor model driving the register port
`timescale 1ns/1ps
`default_nettype none
module hpc_host_model
(
   // clock
   input  wire logic       clock,
   // register port
   output var  logic [4:0] addr = 5'h00,
   output var  logic       rd_strobe = 1'b0,
   output var  logic       wr_strobe = 1'b0,
   output var  logic [7:0] wr_data = 8'h00,
   input  wire logic [7:0] rd_data_reg,
   input  wire logic       ack_reg
);
   // one access; n counts falling edges until the acknowledge
   task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d,
                      output logic [7:0] q, output int n);
      @(negedge clock);
      addr = a;
      wr_data = d;
      wr_strobe = w;
      rd_strobe = !w;
      @(negedge clock);
      wr_strobe = 1'b0;
      rd_strobe = 1'b0;
      wr_data = ~d;
      for (n = 1; n < 40 && ack_reg !== 1'b1; n++)
         @(negedge clock);
      q = rd_data_reg;
   endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the host port control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic       clock, reset_n, config_mode, data_request, stream_user_enable;
   logic       done_pin, init_pin, user_request_n, rd_strobe, wr_strobe, ack_reg;
   logic       irq_n_reg, user_mode_reg, chain_active_reg, chain_data_reg;
   logic [1:0] stream_error;
   logic [4:0] addr;
   logic [7:0] wr_data, rd_data_reg, q, d;
   int         n, i, seed = 48, error_cnt = 0, n_checks = 0;
   hpc_host_model host (.clock, .addr, .rd_strobe, .wr_strobe, .wr_data, .rd_data_reg, .ack_reg);
   hpc_host_port dut (.clock, .reset_n, .addr, .rd_strobe, .wr_strobe, .wr_data, .rd_data_reg,
      .ack_reg, .config_mode, .data_request, .stream_error, .stream_user_enable, .done_pin,
      .init_pin, .user_request_n, .irq_n_reg, .user_mode_reg, .chain_data_reg, .chain_active_reg);
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      n_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task go(input logic w, input logic [4:0] a, input logic [7:0] dv);
      host.acc(w, a, dv, q, n);
      if (n >= 40)
      begin
         error_cnt++;
         stop_test;
      end
   endtask
   task rd(input logic [4:0] a, input logic [7:0] e);
      go(1'b0, a, 8'h00);
      chk(q, e, "read");
   endtask
   task wait_chk(input logic seen_sel, input logic e, input string what);
      repeat (6) @(negedge clock);
      chk({7'h00, seen_sel ? user_mode_reg : irq_n_reg}, {7'h00, e}, what);
   endtask
   initial
   begin
      {config_mode, data_request, stream_error, stream_user_enable, done_pin} = 6'h00;
      {init_pin, user_request_n, reset_n} = 3'h6;
      repeat (20) @(negedge clock);
      reset_n = 1'b1;
      rd(5'h01, 8'h00);
      rd(5'h02, 8'h00);
      repeat (8)
      begin
         d = $random(seed);
         go(1'b1, 5'h02, d);
         go(1'b1, 5'h01, d);
         rd(5'h02, d);
         rd(5'h01, d & 8'h3F);
      end
      go(1'b1, 5'h03, 8'hFF);
      rd(5'h03, 8'h40);
      $display("registers done");
      config_mode = 1'b1;
      for (i = 0; i < 3; i++)
      begin
         go(1'b1, 5'h01, i == 0 ? 8'h09 : 8'h01 << i);
         {user_request_n, stream_error, data_request} = i == 0 ? 4'h9 : i == 1 ? 4'hA : 4'h0;
         wait_chk(1'b0, 1'b0, "irq on");
         go(1'b1, 5'h01, 8'h00);
         wait_chk(1'b0, 1'b1, "irq off");
         {user_request_n, stream_error, data_request} = 4'h8;
      end
      go(1'b1, 5'h01, 8'h02);
      {config_mode, stream_error} = 3'h1;
      wait_chk(1'b0, 1'b1, "err outside config");
      {config_mode, stream_error} = 3'h4;
      $display("interrupts done");
      go(1'b1, 5'h01, 8'h18);
      go(1'b1, 5'h04, 8'hA5);
      chk({7'h00, n > 4}, 8'h01, "held ack");
      go(1'b1, 5'h01, 8'h08);
      go(1'b1, 5'h04, 8'h5A);
      chk(n[7:0], 8'h01, "fast ack");
      d = 8'h00;
      repeat (12)
      begin
         @(negedge clock);
         if (chain_active_reg)
            d = {d[6:0], chain_data_reg};
      end
      chk(d, 8'h5A, "chain bits");
      repeat (16) @(negedge clock);
      go(1'b1, 5'h01, 8'h00);
      go(1'b1, 5'h04, 8'h3C);
      chk({7'h00, chain_active_reg}, 8'h00, "no shift");
      go(1'b1, 5'h01, 8'h20);
      done_pin = 1'b1;
      wait_chk(1'b1, 1'b1, "user mode reg");
      {done_pin, stream_user_enable} = 2'h1;
      go(1'b1, 5'h01, 8'h00);
      done_pin = 1'b1;
      wait_chk(1'b1, 1'b1, "user mode stream");
      $display("config done");
      stop_test;
   end
endmodule
bind hpc_host_port hpc_checker chk_i (.clock, .reset_n, .addr, .rd_strobe, .wr_strobe, .wr_data,
   .config_mode, .done_pin, .user_request_n, .rd_data_reg, .ack_reg, .irq_n_reg, .user_mode_reg,
   .chain_active_reg);
`default_nettype wire
